// *** mnd_pkg.sv ***
// shared constants and types for the multiply and negate datapath
package mnd_pkg;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned LONG_W = 32;
    localparam int unsigned ADDR_W = 8;

    // opcode bytes; the six-bit forms drop the two addressing-mode bits
    localparam logic [7:0] PREFIX_BYTE  = 8'hFE;
    localparam logic [5:0] OPC_MB3_HI   = 6'h17;  // 010111aa
    localparam logic [5:0] OPC_MW2_HI   = 6'h1B;  // 011011aa
    localparam logic [5:0] OPC_MW3_HI   = 6'h13;  // 010011aa
    localparam logic [5:0] OPC_MB2_HI   = 6'h1F;  // 011111aa
    localparam logic [7:0] OPC_NEG_W    = 8'h03;
    localparam logic [7:0] OPC_NEG_B    = 8'h13;
    localparam logic [7:0] OPC_NOP      = 8'hFD;
    localparam int unsigned OPC_HI_LSB  = 2;

    // multiply-accumulate window on the destination address
    localparam logic [ADDR_W-1:0] MAC_ADDR_LIMIT = 8'h10;
    localparam int unsigned MAC_CLR_BIT = 3;

    // write-back sizes
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    localparam logic [LONG_W-1:0] LONG_ZERO = 32'h00000000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_MIN  = 16'h8000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_MIN  = 8'h80;

    // decoded operation class
    typedef enum logic [3:0] {
        OP_NONE  = 4'b0000,
        OP_SMB3  = 4'b0001,
        OP_UMW2  = 4'b0010,
        OP_UMW3  = 4'b0011,
        OP_UMB2  = 4'b0100,
        OP_UMB3  = 4'b0101,
        OP_NEGW  = 4'b0110,
        OP_BYTE_NEGATE  = 4'b0111,
        OP_NOP   = 4'b1000,
        OP_UNSUP = 4'b1001
    } mnd_op_t;
endpackage : mnd_pkg

// *** mnd_mul.sv ***
// shared 16x16 multiplier, bytes signed or unsigned, words always unsigned
`timescale 1ns/1ps
module mnd_mul (
    input  wire logic [mnd_pkg::WORD_W-1:0] a_i,
    input  wire logic [mnd_pkg::WORD_W-1:0] b_i,
    input  wire logic                       byte_i,
    input  wire logic                       signed_i,
    output logic      [mnd_pkg::LONG_W-1:0] prod_o
);
    import mnd_pkg::*;

    logic [WORD_W-1:0] a_ext;
    logic [WORD_W-1:0] b_ext;
    logic [LONG_W-1:0] full;

    // byte operands are widened first; low half of the product is exact for both signs
    always_comb begin
        a_ext = a_i;
        b_ext = b_i;
        if (byte_i) begin
            a_ext = {{BYTE_W{signed_i & a_i[BYTE_W-1]}}, a_i[BYTE_W-1:0]};
            b_ext = {{BYTE_W{signed_i & b_i[BYTE_W-1]}}, b_i[BYTE_W-1:0]};
        end
        full   = {WORD_ZERO, a_ext} * {WORD_ZERO, b_ext};
        prod_o = byte_i ? {WORD_ZERO, full[WORD_W-1:0]} : full;
    end
endmodule : mnd_mul

// *** mnd_acc.sv ***
// multiply-accumulate register with clear-before-add
`timescale 1ns/1ps
module mnd_acc (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       add_i,
    input  wire logic                       clr_i,
    input  wire logic [mnd_pkg::LONG_W-1:0] prod_i,
    output logic      [mnd_pkg::LONG_W-1:0] acc_o
);
    import mnd_pkg::*;

    logic [LONG_W-1:0] acc_r;
    logic [LONG_W-1:0] acc_nxt;

    // clear only matters together with an add; the sum wraps at 32 bits
    always_comb begin
        acc_nxt = acc_r;
        if (add_i) begin
            acc_nxt = (clr_i ? LONG_ZERO : acc_r) + prod_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_r <= LONG_ZERO;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign acc_o = acc_r;
endmodule : mnd_acc

// *** mnd_core.sv ***
// multiply / negate / no-op execution datapath with opcode decode
//
// Notes on behaviour
// - signed byte multiply gives 16-bit word product
// - prefix FE then 010111aa decodes signed byte
// - two-operand word multiply, unsigned, 32-bit result
// - unprefixed 011011aa decodes two-operand word multiply
// - three-operand word multiply, unsigned, 32-bit result
// - unprefixed 010011aa decodes three-operand word multiply
// - low destination adds product into accumulator
// - destination bit 3 clears accumulator first
// - sticky flag free after unsigned multiplies
// - 011111aa is two-operand unsigned byte multiply
// - unprefixed 010111aa is three-operand unsigned byte
// - 00000011 negates a word register
// - 00010011 negates a byte register
// - FD is no-op, nothing changes
`timescale 1ns/1ps
module mnd_core (
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       mac_present_i,
    input  wire logic                       issue_i,
    input  wire logic                       prefix_i,
    input  wire logic [7:0]                 opcode_i,
    input  wire logic [mnd_pkg::WORD_W-1:0] opa_i,
    input  wire logic [mnd_pkg::WORD_W-1:0] opb_i,
    input  wire logic [mnd_pkg::ADDR_W-1:0] dest_addr_i,
    input  wire logic                       vt_i,
    input  wire logic                       st_i,
    output logic                            done_o,
    output logic                            wb_valid_o,
    output logic      [mnd_pkg::ADDR_W-1:0] wb_addr_o,
    output logic      [mnd_pkg::LONG_W-1:0] wb_data_o,
    output logic      [1:0]                 wb_size_o,
    output logic                            flag_we_o,
    output logic                            flag_z_o,
    output logic                            flag_n_o,
    output logic                            flag_c_o,
    output logic                            flag_v_o,
    output logic                            flag_vt_o,
    output logic                            flag_st_o,
    output logic                            acc_upd_o,
    output logic      [mnd_pkg::LONG_W-1:0] acc_o,
    output logic                            nop_o,
    output logic                            unsup_o
);
    import mnd_pkg::*;

    // decode
    mnd_op_t     op;
    logic [5:0]  opc_hi;

    // for the multiplies the two low opcode bits only pick the addressing mode; negate and no-op decode all eight bits
    assign opc_hi = opcode_i[7:OPC_HI_LSB];

    // the prefix turns unsigned forms into signed ones; only the signed
    // byte three-operand form lives here, other prefixed forms are refused
    always_comb begin
        op = OP_NONE;
        if (issue_i) begin
            op = OP_UNSUP;
            if (prefix_i) begin
                if (opc_hi == OPC_MB3_HI) begin
                    op = OP_SMB3;
                end
            end else begin
                case (opc_hi)
                    OPC_MW2_HI: op = OP_UMW2;
                    OPC_MW3_HI: op = OP_UMW3;
                    OPC_MB2_HI: op = OP_UMB2;
                    OPC_MB3_HI: op = OP_UMB3;
                    default: begin
                        case (opcode_i)
                            OPC_NEG_W: op = OP_NEGW;
                            OPC_NEG_B: op = OP_BYTE_NEGATE;
                            OPC_NOP:   op = OP_NOP;
                            default:   op = OP_UNSUP;
                        endcase
                    end
                endcase
            end
        end
    end

    // multiplier operand steering
    logic              mul_byte;
    logic              mul_signed;
    logic [LONG_W-1:0] prod;

    // two-operand forms carry the old destination value on opb
    always_comb begin
        mul_byte   = 1'b0;
        mul_signed = 1'b0;
        case (op)
            OP_SMB3: begin
                mul_byte   = 1'b1;
                mul_signed = 1'b1;
            end
            OP_UMB2,
            OP_UMB3: begin
                mul_byte   = 1'b1;
            end
            default: begin
                mul_byte   = 1'b0;
            end
        endcase
    end

    // one shared multiplier serves every multiply form; only the steering differs
    mnd_mul u_mul (
        .a_i      (opa_i),
        .b_i      (opb_i),
        .byte_i   (mul_byte),
        .signed_i (mul_signed),
        .prod_o   (prod)
    );

    // multiply-accumulate
    logic mac_hit;
    logic mac_clr;

    // without the accumulator the low addresses are plain registers
    assign mac_hit = mac_present_i && (op == OP_UMW3)
                     && (dest_addr_i < MAC_ADDR_LIMIT);
    assign mac_clr = dest_addr_i[MAC_CLR_BIT];

    // the clear bit is ignored by the accumulator unless a hit is decoded
    mnd_acc u_acc (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .add_i     (mac_hit),
        .clr_i     (mac_clr),
        .prod_i    (prod),
        .acc_o     (acc_o)
    );

    // negate and its flags
    logic [WORD_W-1:0] neg_w;
    logic [BYTE_W-1:0] neg_b;

    // both widths are always formed; the decode picks which one is stored
    assign neg_w = WORD_ZERO - opb_i;
    assign neg_b = BYTE_ZERO - opb_i[BYTE_W-1:0];

    // result registers
    logic              done_r,  done_nxt;
    logic              wbv_r,   wbv_nxt;
    logic [ADDR_W-1:0] wba_r,   wba_nxt;
    logic [LONG_W-1:0] wbd_r,   wbd_nxt;
    logic [1:0]        wbs_r,   wbs_nxt;
    logic              fwe_r,   fwe_nxt;
    logic              fz_r,    fz_nxt;
    logic              fn_r,    fn_nxt;
    logic              fc_r,    fc_nxt;
    logic              fv_r,    fv_nxt;
    logic              fvt_r,   fvt_nxt;
    logic              fst_r,   fst_nxt;
    logic              accu_r,  accu_nxt;
    logic              nop_r,   nop_nxt;
    logic              uns_r,   uns_nxt;

    // one result per issue, presented for one cycle after the issue edge;
    // the data holds its value between results so a late reader still sees it
    always_comb begin
        done_nxt = (op != OP_NONE);
        wbv_nxt  = 1'b0;
        wba_nxt  = wba_r;
        wbd_nxt  = wbd_r;
        wbs_nxt  = wbs_r;
        fwe_nxt  = 1'b0;
        fz_nxt   = fz_r;
        fn_nxt   = fn_r;
        fc_nxt   = fc_r;
        fv_nxt   = fv_r;
        fvt_nxt  = fvt_r;
        fst_nxt  = fst_r;
        accu_nxt = 1'b0;
        nop_nxt  = 1'b0;
        uns_nxt  = 1'b0;
        case (op)
            OP_SMB3,
            OP_UMB2,
            OP_UMB3: begin
                // byte products land in a word, flags untouched
                wbv_nxt = 1'b1;
                wba_nxt = dest_addr_i;
                wbd_nxt = {WORD_ZERO, prod[WORD_W-1:0]};
                wbs_nxt = SIZE_WORD;
            end
            OP_UMW2: begin
                wbv_nxt = 1'b1;
                wba_nxt = dest_addr_i;
                wbd_nxt = prod;
                wbs_nxt = SIZE_LONG;
            end
            OP_UMW3: begin
                // an accumulate replaces the normal store
                wbv_nxt  = !mac_hit;
                accu_nxt = mac_hit;
                wba_nxt  = dest_addr_i;
                wbd_nxt  = prod;
                wbs_nxt  = SIZE_LONG;
            end
            OP_NEGW: begin
                wbv_nxt = 1'b1;
                wba_nxt = dest_addr_i;
                wbd_nxt = {WORD_ZERO, neg_w};
                wbs_nxt = SIZE_WORD;
                fwe_nxt = 1'b1;
                fz_nxt  = (neg_w == WORD_ZERO);
                fn_nxt  = neg_w[WORD_W-1];
                fc_nxt  = (opb_i == WORD_ZERO);  // no borrow out
                fv_nxt  = (opb_i == WORD_MIN);
                fvt_nxt = vt_i | (opb_i == WORD_MIN);
                fst_nxt = st_i;
            end
            OP_BYTE_NEGATE: begin
                wbv_nxt = 1'b1;
                wba_nxt = dest_addr_i;
                wbd_nxt = {WORD_ZERO, BYTE_ZERO, neg_b};
                wbs_nxt = SIZE_BYTE;
                fwe_nxt = 1'b1;
                fz_nxt  = (neg_b == BYTE_ZERO);
                fn_nxt  = neg_b[BYTE_W-1];
                fc_nxt  = (opb_i[BYTE_W-1:0] == BYTE_ZERO);
                fv_nxt  = (opb_i[BYTE_W-1:0] == BYTE_MIN);
                fvt_nxt = vt_i | (opb_i[BYTE_W-1:0] == BYTE_MIN);
                fst_nxt = st_i;
            end
            OP_NOP: begin
                nop_nxt = 1'b1;
            end
            OP_UNSUP: begin
                uns_nxt = 1'b1;
            end
            default: begin
                done_nxt = 1'b0;
            end
        endcase
        // sticky flag is never written by a multiply, which is allowed
        // since its value after one is left open
        if (op == OP_UMW2 || op == OP_UMW3 || op == OP_UMB2 || op == OP_UMB3) begin
            fst_nxt = fst_r;
        end
    end

    // plain register stage; reset leaves every pulse low and the flags clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_r <= 1'b0;
            wbv_r  <= 1'b0;
            wba_r  <= '0;
            wbd_r  <= LONG_ZERO;
            wbs_r  <= SIZE_BYTE;
            fwe_r  <= 1'b0;
            fz_r   <= 1'b0;
            fn_r   <= 1'b0;
            fc_r   <= 1'b0;
            fv_r   <= 1'b0;
            fvt_r  <= 1'b0;
            fst_r  <= 1'b0;
            accu_r <= 1'b0;
            nop_r  <= 1'b0;
            uns_r  <= 1'b0;
        end else begin
            done_r <= done_nxt;
            wbv_r  <= wbv_nxt;
            wba_r  <= wba_nxt;
            wbd_r  <= wbd_nxt;
            wbs_r  <= wbs_nxt;
            fwe_r  <= fwe_nxt;
            fz_r   <= fz_nxt;
            fn_r   <= fn_nxt;
            fc_r   <= fc_nxt;
            fv_r   <= fv_nxt;
            fvt_r  <= fvt_nxt;
            fst_r  <= fst_nxt;
            accu_r <= accu_nxt;
            nop_r  <= nop_nxt;
            uns_r  <= uns_nxt;
        end
    end

    // outputs straight from the result registers
    assign done_o     = done_r;
    assign wb_valid_o = wbv_r;
    assign wb_addr_o  = wba_r;
    assign wb_data_o  = wbd_r;
    assign wb_size_o  = wbs_r;
    assign flag_we_o  = fwe_r;
    assign flag_z_o   = fz_r;
    assign flag_n_o   = fn_r;
    assign flag_c_o   = fc_r;
    assign flag_v_o   = fv_r;
    assign flag_vt_o  = fvt_r;
    assign flag_st_o  = fst_r;
    assign acc_upd_o  = accu_r;
    assign nop_o      = nop_r;
    assign unsup_o    = uns_r;
endmodule : mnd_core

// *** mnd_sva.sv ***
// assertion checker for the multiply and negate datapath
`timescale 1ns/1ps
module mnd_sva
    import mnd_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        mac_present_i,
    input wire logic        issue_i,
    input wire logic        prefix_i,
    input wire logic [7:0]  opcode_i,
    input wire logic [15:0] opa_i,
    input wire logic [15:0] opb_i,
    input wire logic [7:0]  dest_addr_i,
    input wire logic        done_o,
    input wire logic        wb_valid_o,
    input wire logic [31:0] wb_data_o,
    input wire logic [1:0]  wb_size_o,
    input wire logic        flag_we_o,
    input wire logic        acc_upd_o,
    input wire logic [31:0] acc_o,
    input wire logic        nop_o
);
    logic [15:0] a_q, b_q;
    logic [31:0] wp;
    logic [5:0]  hi;
    logic        ok, mw, mac, umb;
    // operands kept one cycle so the answer can be tied to them
    always_ff @(posedge clk_sys_i) begin
        a_q <= opa_i;
        b_q <= opb_i;
    end
    // instruction classes at the taking edge
    always_comb begin
        wp  = a_q * b_q;
        hi  = opcode_i[7:2];
        ok  = issue_i && !prefix_i;
        mw  = ok && (hi == OPC_MW2_HI || hi == OPC_MW3_HI);
        mac = ok && hi == OPC_MW3_HI && mac_present_i && dest_addr_i < MAC_ADDR_LIMIT;
        umb = ok && (hi == OPC_MB2_HI || hi == OPC_MB3_HI);
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    a_done_each: assert property (issue_i |=> done_o)
        else $error("no done after issue");
    a_signed_byte: assert property (issue_i && prefix_i && hi == OPC_MB3_HI |=> wb_valid_o
        && wb_data_o == {16'h0000, {{8{a_q[7]}}, a_q[7:0]} * {{8{b_q[7]}}, b_q[7:0]}})
        else $error("signed byte product wrong");
    a_word_mul: assert property (mw && !mac |=> wb_valid_o && wb_size_o == SIZE_LONG
        && wb_data_o == wp) else $error("word product wrong");
    a_mac_nowb: assert property (mac |=> acc_upd_o && !wb_valid_o)
        else $error("accumulate wrote a register");
    a_mac_clear: assert property (mac && dest_addr_i[MAC_CLR_BIT] |=> acc_o == wp)
        else $error("accumulator not cleared first");
    a_mac_add: assert property (mac && !dest_addr_i[MAC_CLR_BIT] |=> acc_o == $past(acc_o) + wp)
        else $error("accumulator sum wrong");
    a_byte_umul: assert property (umb |=> wb_valid_o && wb_size_o == SIZE_WORD
        && wb_data_o == a_q[7:0] * b_q[7:0]) else $error("unsigned byte product wrong");
    a_word_neg: assert property (ok && opcode_i == OPC_NEG_W |=> wb_valid_o && flag_we_o
        && wb_data_o[15:0] == WORD_ZERO - b_q) else $error("word negate wrong");
    a_byte_neg: assert property (ok && opcode_i == OPC_NEG_B |=> flag_we_o
        && wb_data_o[7:0] == BYTE_ZERO - b_q[7:0]) else $error("byte negate wrong");
    a_mul_noflag: assert property (mw || umb |=> !flag_we_o)
        else $error("multiply wrote flags");
    a_nop_quiet: assert property (ok && opcode_i == OPC_NOP |=> nop_o && !wb_valid_o
        && !flag_we_o && !acc_upd_o) else $error("no-op changed state");
endmodule : mnd_sva

// *** mnd_feed.sv ***
// instruction feed standing in for fetch, decode and register file
`timescale 1ns/1ps
module mnd_feed (
    input  wire logic   clk_sys_i,
    output logic        issue_o,
    output logic        prefix_o,
    output logic [7:0]  opcode_o,
    output logic [15:0] opa_o,
    output logic [15:0] opb_o,
    output logic [7:0]  dest_o,
    output logic        vt_o,
    output logic        st_o
);
    // quiet at time zero
    initial begin
        {issue_o, prefix_o, opcode_o, opa_o, opb_o, dest_o, vt_o, st_o} = '0;
    end
    // one instruction per call, held until the next falling edge
    task send(input logic p, input logic [7:0] op, input logic [15:0] a, b,
              input logic [7:0] d, input logic v, s);
        {issue_o, prefix_o, opcode_o, opa_o, opb_o, dest_o, vt_o, st_o} = {1'b1, p, op, a, b, d, v, s};
        @(negedge clk_sys_i);
    endtask : send
    // released prefix, opcode, operand and address lines show the inverse so no stale value passes for a real one; vt and st hold
    task idle();
        {issue_o, prefix_o, opcode_o, opa_o, opb_o, dest_o} =
            {1'b0, ~prefix_o, ~opcode_o, ~opa_o, ~opb_o, ~dest_o};
        @(negedge clk_sys_i);
    endtask : idle
endmodule : mnd_feed

// *** mnd_core_tb.sv ***
// self-checking bench for the multiply and negate datapath
`timescale 1ns/1ps
module mnd_core_tb;
    import mnd_pkg::*;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, mac_present_i = 1'b0;
    logic        issue_i, prefix_i, vt_i, st_i, done_o, wb_valid_o, flag_we_o;
    logic        flag_z_o, flag_n_o, flag_c_o, flag_v_o, flag_vt_o, flag_st_o;
    logic        acc_upd_o, nop_o, unsup_o;
    logic [7:0]  opcode_i, dest_addr_i, wb_addr_o;
    logic [15:0] opa_i, opb_i;
    logic [31:0] wb_data_o, acc_o, acc_m;
    logic [31:0] exp_q [$];
    logic [5:0]  flags_m = 6'h00;
    logic [1:0]  wb_size_o;
    int          fail_count = 0, check_count = 0;
    integer      seed = 32'hB120;
    logic [8:0]  ops [10] = '{9'h15C, 9'h06C, 9'h04C, 9'h07C, 9'h05C,
                              9'h003, 9'h013, 9'h0FD, 9'h020, 9'h16C};
    mnd_core uut (.clk_sys_i, .rst_n_i, .mac_present_i, .issue_i, .prefix_i, .opcode_i,
        .opa_i, .opb_i, .dest_addr_i, .vt_i, .st_i, .done_o, .wb_valid_o, .wb_addr_o,
        .wb_data_o, .wb_size_o, .flag_we_o, .flag_z_o, .flag_n_o, .flag_c_o, .flag_v_o,
        .flag_vt_o, .flag_st_o, .acc_upd_o, .acc_o, .nop_o, .unsup_o);
    mnd_feed feed (.clk_sys_i, .issue_o(issue_i), .prefix_o(prefix_i), .opcode_o(opcode_i),
        .opa_o(opa_i), .opb_o(opb_i), .dest_o(dest_addr_i), .vt_o(vt_i), .st_o(st_i));
    // 25 MHz clock
    always #20 clk_sys_i = ~clk_sys_i;
    task cmp(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    // one random instruction, modelled, issued back to back and checked
    task run_one(input int k);
        logic [8:0]  o;
        logic [15:0] a, b;
        logic [7:0]  d, op;
        logic        p, v, s, ev, fw, au, en, eu;
        logic [1:0]  sz;
        logic [31:0] ed, m, mk;
        logic [5:0]  ef, fs;
        int          t;
        o = ops[$unsigned($random(seed)) % 10];
        p = o[8];
        op = o[7:0] | (o[3:0] == 4'hC ? 8'($random(seed)) & 8'h03 : 8'h00);
        a = 16'($random(seed));
        b = (k % 3 == 0) ? 16'h8000 >> (k % 17) : 16'($random(seed));
        d = 8'($random(seed)) & 8'h1F;
        {v, s} = 2'($random(seed));
        mac_present_i = 1'($random(seed));
        {ev, fw, au, en, eu, sz, ed, ef} = '0;
        m = a * b;
        if (p) begin
            t = int'($signed(a[7:0])) * int'($signed(b[7:0]));
            if (op[7:2] == OPC_MB3_HI) {ev, sz, ed} = {1'b1, SIZE_WORD, 32'(t) & 32'h0000FFFF};
            else eu = 1'b1;
        end else if (op[7:2] == OPC_MW2_HI || op[7:2] == OPC_MW3_HI) begin
            if (op[7:2] == OPC_MW3_HI && mac_present_i && d < 8'h10) begin
                au = 1'b1;
                acc_m = (d[3] ? 32'h00000000 : acc_m) + m;
            end else {ev, sz, ed} = {1'b1, SIZE_LONG, m};
        end else if (op[7:2] == OPC_MB2_HI || op[7:2] == OPC_MB3_HI) begin
            t = a[7:0] * b[7:0];
            {ev, sz, ed} = {1'b1, SIZE_WORD, 32'(t)};
        end else if (op == OPC_NEG_W) begin
            t = -int'(b);
            ed = 32'(t) & 32'h0000FFFF;
            {ev, fw, sz} = {2'b11, SIZE_WORD};
            ef = {ed[15:0] == 16'h0000, ed[15], b == 16'h0000, b == WORD_MIN, v | b == WORD_MIN, s};
        end else if (op == OPC_NEG_B) begin
            t = -int'(b[7:0]);
            ed = 32'(t) & 32'h000000FF;
            {ev, fw, sz} = {2'b11, SIZE_BYTE};
            ef = {ed[7:0] == 8'h00, ed[7], b[7:0] == 8'h00, b[7:0] == 8'h80, v | b[7:0] == 8'h80, s};
        end else if (op == OPC_NOP) en = 1'b1;
        else eu = 1'b1;
        mk = sz == SIZE_BYTE ? 32'h000000FF : fw ? 32'h0000FFFF : 32'hFFFFFFFF;
        // expected write-back results queue up in issue order
        if (ev) exp_q.push_back(ed);
        feed.send(p, op, a, b, d, v, s);
        cmp("done", 32'h1, done_o);
        cmp("wb_valid", ev, wb_valid_o);
        if (ev) begin
            cmp("wb_addr", d, wb_addr_o);
            cmp("wb_size", sz, wb_size_o);
            cmp("wb_data", exp_q.pop_front(), wb_data_o & mk);
        end
        cmp("flag_we", fw, flag_we_o);
        // flags hold between negates; sticky is only checked right after a negate
        if (fw) flags_m = ef;
        fs = {flag_z_o, flag_n_o, flag_c_o, flag_v_o, flag_vt_o, fw & flag_st_o};
        cmp("flags", {flags_m[5:1], fw & flags_m[0]}, fs);
        cmp("acc_upd", au, acc_upd_o);
        cmp("acc", acc_m, acc_o);
        cmp("nop", en, nop_o);
        cmp("unsup", eu, unsup_o);
    endtask : run_one
    // main sequence: reset, then a long random run with a gap now and then
    initial begin
        acc_m = 32'h00000000;
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        cmp("acc_reset", 32'h0, acc_o);
        $display("test reset done");
        for (int k = 0; k < 400; k++) begin
            run_one(k);
            if (k % 16 == 15) begin
                feed.idle();
                cmp("done_idle", 32'h0, done_o);
            end
        end
        $display("test random done");
        summarize();
    end
    // watchdog: far beyond the roughly 430 cycles the run needs
    initial begin
        #(2000 * 40);
        fail_count++;
        summarize();
    end
endmodule : mnd_core_tb
bind mnd_core mnd_sva chk (.clk_sys_i, .rst_n_i, .mac_present_i, .issue_i, .prefix_i,
    .opcode_i, .opa_i, .opb_i, .dest_addr_i, .done_o, .wb_valid_o, .wb_data_o, .wb_size_o,
    .flag_we_o, .acc_upd_o, .acc_o, .nop_o);
